// *** tds_top.sv ***
// Purpose: Trigger-to-sample delay sequencer with parallel output ports
// Assumes: All inputs synchronous to clk_i; analog parts are outside
// Notes:   Fine delay below one sequencing period is done by the ramp
`timescale 1ns/1ns
module tds_top
  import tds_pkg::*;
(
  input  wire logic                clk_i,         // 100 MHz clock
  input  wire logic                rst_i,         // Sync reset, high
  input  wire logic                cyc_i,         // Wishbone cycle
  input  wire logic                stb_i,         // Wishbone strobe
  input  wire logic                we_i,          // Write enable
  input  wire logic [3:1]          adr_i,         // Word address
  input  wire logic [1:0]          sel_i,         // Byte lanes
  input  wire logic [15:0]         dat_i,         // Write data
  output logic      [15:0]         dat_o,         // Read data
  output logic                     ack_o,         // Acknowledge
  input  wire logic                trig_a_n_i,    // Channel A trigger
  input  wire logic                trig_b_n_i,    // Channel B trigger
  input  wire logic                trig_ext_n_i,  // External trigger
  input  wire logic                cmp_i,         // Sample comparator
  input  wire logic                kbd_irq_i,     // Keyboard request
  input  wire logic                gpib_irq_i,    // GPIB request
  output logic      [7:0]          fine_delay_o,  // Fine delay DAC
  output logic      [9:0]          trig_level_o,  // Trigger level DAC
  output logic                     ramp_on_o,     // Ramp running
  output logic                     ramp_preset_o, // Ramp at start
  output logic                     hold_sample_o, // Hold sampling
  output logic                     hold_active_o, // Hold engaged
  output logic                     cmp_latch_o,   // Freeze comparator
  output logic                     sample1_o,     // First sample pulse
  output logic                     sample2_o,     // Second sample pulse
  output logic                     ready_o,       // Front panel ready
  output logic                     irq_o,         // Sample done irq
  output logic                     halt_o         // Processor halt
);
  import tds_pkg::*;

  logic [7:0]          port_q [8];
  tds_state_t          state;
  logic [SEQ_ACC_W:0]  next_acc;
  logic [SEQ_ACC_W-1:0] acc;
  logic [4:0]          stretch_cnt;
  logic [8:0]          hold_cnt;
  logic [2:0]          rst_cnt;
  logic [COARSE_W-1:0] load_val, count;
  logic [3:0]          cmd_lines_n, cmd_lines_q;
  logic [1:0]          src, cmd;
  logic                seq_tick, stretched, stretched_q, board_rst;
  logic                halt_armed, rst_pulse, trig_sel_n, wr_stb;
  logic                new_data_ack;

  // Every check below runs on clk_i and sleeps through reset
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Active-low one-hot command lines
  function automatic logic [3:0] cmd_decode(input logic [1:0] c);
    logic [3:0] l;
    l = 4'hf;
    l[c] = 1'b0;
    return l;
  endfunction : cmd_decode

  assign src          = port_q[6][HC_SRC_LO+:2];
  assign cmd          = port_q[6][HC_CMD_LO+:2];
  assign new_data_ack = port_q[6][HC_ACK];
  assign cmd_lines_n  = cmd_decode(cmd);
  assign wr_stb       = cyc_i & stb_i & we_i & ack_o;
  assign rst_pulse    = (rst_cnt != 3'h0);

  // Wishbone: one wait state, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 16'h0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (adr_i == STATUS_ADR) begin
        dat_o <= {8'h00, halt_o, irq_o, ready_o, board_rst,
                  ramp_on_o, hold_active_o, cmp_latch_o, halt_armed};
      end else if (adr_i[3]) begin
        dat_o <= 16'h0000;
      end else begin
        dat_o <= {port_q[{1'b1, adr_i[2:1]}], port_q[{1'b0, adr_i[2:1]}]};
      end
    end
  end

  // Low lane writes the low chip, high lane the high chip
  for (genvar g = 0; g < 8; g++) begin : g_port
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        port_q[g] <= PORT_RST;
      end else if (wr_stb && !adr_i[3] && adr_i[2:1] == 2'(g % 4)
                   && sel_i[g/4]) begin
        port_q[g] <= dat_i[(g/4)*8 +: 8];
      end
    end
  end

  // Trigger level follows the ports; fine delay loads from port 0 on the load command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_level_o <= 10'h000;
      fine_delay_o <= 8'hff;
    end else begin
      trig_level_o <= {port_q[6][HC_LVL_LO+:2], port_q[2]};
      if (!cmd_lines_n[CMD_LOAD]) begin
        fine_delay_o <= ~port_q[0];
      end
    end
  end

  // Coarse count stored inverted: delay = max - value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_val <= '1;
    end else if (!cmd_lines_n[CMD_LOAD]) begin
      load_val <= ~{port_q[5], port_q[4], port_q[1]};
    end
  end

  // Phase accumulator gives exact 25.6 ns average period
  assign next_acc = {1'b0, acc} + {1'b0, SEQ_ACC_STEP};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc      <= '0;
      seq_tick <= 1'b0;
    end else begin
      acc      <= next_acc[SEQ_ACC_W-1:0];
      seq_tick <= next_acc[SEQ_ACC_W];
    end
  end

  // Command line history for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_lines_q <= 4'hf;
    end else begin
      cmd_lines_q <= cmd_lines_n;
    end
  end

  // Reset pulse from the falling edge of the reset line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt <= 3'h0;
    end else if (cmd_lines_q[CMD_RESET] && !cmd_lines_n[CMD_RESET]) begin
      rst_cnt <= 3'(RST_PULSE_CYC);
    end else if (rst_pulse) begin
      rst_cnt <= rst_cnt - 3'h1;
    end
  end

  // Soft trigger is the reset pulse's last cycle, after the release,
  // so the edge detector sees it while the sequence is armed
  always_comb begin
    case (src)
      SRC_CHAN_A: trig_sel_n = trig_a_n_i;
      SRC_CHAN_B: trig_sel_n = trig_b_n_i;
      SRC_SOFT:   trig_sel_n = (rst_cnt != 3'h1);
      SRC_EXT:    trig_sel_n = trig_ext_n_i;
      default:    trig_sel_n = 1'b1;
    endcase
  end

  // Stretcher keeps the pulse 200 ns past its last trailing edge
  assign stretched = ~trig_sel_n | (stretch_cnt != 5'h00);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stretch_cnt <= 5'h00;
      stretched_q <= 1'b0;
    end else begin
      if (!trig_sel_n) begin
        stretch_cnt <= 5'(STRETCH_CYC);
      end else if (stretch_cnt != 5'h00) begin
        stretch_cnt <= stretch_cnt - 5'h01;
      end
      stretched_q <= stretched;
    end
  end

  // Board reset latch: set by load or second sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      board_rst <= 1'b1;
    end else if (state == TDS_ST_SAMPLE2) begin
      board_rst <= 1'b1;
    end else if (!cmd_lines_n[CMD_LOAD]) begin
      board_rst <= 1'b1;
    end else if (rst_cnt == 3'(RST_PULSE_CYC)) begin
      board_rst <= 1'b0;
    end
  end

  // Main sequence; tick plays both clock phases of the slow clock
  always_ff @(posedge clk_i) begin
    if (rst_i || board_rst) begin
      state <= TDS_ST_BOARD_RST;
      count <= '0;
    end else begin
      case (state)
        TDS_ST_BOARD_RST: state <= TDS_ST_ARMED;
        TDS_ST_ARMED: begin
          if (stretched && !stretched_q) begin
            state <= TDS_ST_RAMP1;
          end
        end
        TDS_ST_RAMP1: begin
          if (seq_tick) begin
            state <= TDS_ST_GATE;
          end
        end
        TDS_ST_GATE: begin
          if (seq_tick) begin
            state <= TDS_ST_COUNT;
            count <= load_val;
          end
        end
        TDS_ST_COUNT: begin
          if (seq_tick) begin
            if (count == '0) begin
              state <= TDS_ST_RAMP2;
            end else begin
              count <= count - 1'b1;
            end
          end
        end
        TDS_ST_RAMP2: begin
          if (cmp_i) begin
            state <= TDS_ST_SAMPLE1;
          end
        end
        TDS_ST_SAMPLE1: state <= TDS_ST_SAMPLE2;
        TDS_ST_SAMPLE2: state <= TDS_ST_SAMPLE2;
        default:        state <= TDS_ST_BOARD_RST;
      endcase
    end
  end

  // Outputs registered from the next state, except ramp_on_o's RAMP1 term, which uses the current state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_on_o     <= 1'b0;
      ramp_preset_o <= 1'b1;
      ready_o       <= 1'b1;
      cmp_latch_o   <= 1'b1;
      sample1_o     <= 1'b0;
      sample2_o     <= 1'b0;
    end else begin
      // On for a cycle at least, even when a tick follows the trigger
      ramp_on_o     <= (state == TDS_ST_RAMP1)
                    || (state == TDS_ST_COUNT && seq_tick && count == '0)
                    || (state == TDS_ST_RAMP2 && !cmp_i);
      ramp_preset_o <= board_rst;
      ready_o       <= board_rst;
      cmp_latch_o   <= board_rst || state == TDS_ST_SAMPLE1
                    || state == TDS_ST_SAMPLE2
                    || (state == TDS_ST_RAMP2 && cmp_i);
      sample1_o     <= state == TDS_ST_RAMP2 && cmp_i && !board_rst;
      sample2_o     <= state == TDS_ST_SAMPLE1 && !board_rst;
    end
  end

  // Hold: 3.3 us sample window, engaged until acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt      <= 9'h000;
      hold_sample_o <= 1'b0;
      hold_active_o <= 1'b0;
    end else begin
      if (state == TDS_ST_ARMED && !board_rst && stretched
          && !stretched_q) begin
        hold_cnt      <= 9'(HOLD_CYC - 1);
        hold_sample_o <= 1'b1;
        hold_active_o <= 1'b1;
      end else begin
        if (hold_cnt != 9'h000) begin
          hold_cnt <= hold_cnt - 9'h001;
        end else begin
          hold_sample_o <= 1'b0;
        end
        if (new_data_ack) begin
          hold_active_o <= 1'b0;
        end
      end
    end
  end

  // Interrupt latch; a new sample wins over the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (state == TDS_ST_SAMPLE2 && sample2_o) begin
      irq_o <= 1'b1;
    end else if (new_data_ack) begin
      irq_o <= 1'b0;
    end
  end

  // Halt latches: arm, then reset line rising edge asserts
  always_ff @(posedge clk_i) begin
    if (rst_i || kbd_irq_i || gpib_irq_i) begin
      halt_armed <= 1'b0;
      halt_o     <= 1'b0;
    end else if (sample2_o) begin
      halt_armed <= 1'b0;
      halt_o     <= 1'b0;
    end else begin
      if (!cmd_lines_n[CMD_HALT_ARM]) begin
        halt_armed <= 1'b1;
      end
      if (!cmd_lines_q[CMD_RESET] && cmd_lines_n[CMD_RESET]
          && halt_armed) begin
        halt_o <= 1'b1;
      end
    end
  end

  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held two cycles");
  property p_stretch;
    $rose(trig_sel_n) |-> stretched [*8];
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretch ended early");
  sequence s_sample2;
    state == TDS_ST_SAMPLE1 && !board_rst ##1 sample2_o;
  endsequence
  property p_sample_done;
    s_sample2 |=> board_rst && irq_o && !halt_o;
  endproperty
  a_sample_done: assert property (p_sample_done)
    else $error("second sample did not finish");
  // Latch may drop right after, so only the next cycle is checked
  property p_board_rst;
    board_rst |=> state == TDS_ST_BOARD_RST && ready_o && ramp_preset_o;
  endproperty
  a_board_rst: assert property (p_board_rst)
    else $error("board latch did not hold sequence");
  property p_load;
    !cmd_lines_n[CMD_LOAD] |=> board_rst;
  endproperty
  a_load: assert property (p_load)
    else $error("load did not set board latch");
  property p_ack_clear;
    new_data_ack && !sample2_o |=> !irq_o && !hold_active_o;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledge did not clear");
  property p_gate;
    state == TDS_ST_RAMP1 && seq_tick && !board_rst
      |=> ##1 !ramp_on_o;
  endproperty
  a_gate: assert property (p_gate)
    else $error("ramp not off after gate edge");
  property p_tick;
    seq_tick |=> !seq_tick ##1 ##[0:2] seq_tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("sequencing rate wrong");
  property p_halt;
    $rose(halt_o) |-> $past(halt_armed);
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt without arm");
endmodule : tds_top

// *** tds_pkg.sv ***
// Purpose: Constants for the triggered delay sequencer
// Assumes: 100 MHz system clock, 16-bit classic Wishbone slave
// Notes:   Port index is {chip, A2, A1}; chip 1 is the high byte lane
package tds_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned SEQ_ACC_W     = 6;
  // 39.0625 MHz / 100 MHz = 25/64
  localparam logic [5:0]  SEQ_ACC_STEP  = 6'h19;
  localparam int unsigned STRETCH_NS    = 200;
  localparam int unsigned STRETCH_CYC   = (STRETCH_NS * CLK_MHZ) / 1000;
  localparam int unsigned HOLD_NS       = 3300;
  localparam int unsigned HOLD_CYC      = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RST_PULSE_CYC = 4;
  localparam int unsigned COARSE_W      = 24;
  // Port indices inside a chip
  localparam logic [1:0]  PORT_A        = 2'h0;
  localparam logic [1:0]  PORT_B        = 2'h1;
  localparam logic [1:0]  PORT_C        = 2'h2;
  localparam logic [1:0]  PORT_CTRL     = 2'h3;
  // Word address of the status register (adr_i[3:1])
  localparam logic [2:0]  STATUS_ADR    = 3'h4;
  // High chip port C fields
  localparam int unsigned HC_LVL_LO     = 0;
  localparam int unsigned HC_SRC_LO     = 2;
  localparam int unsigned HC_CMD_LO     = 4;
  localparam int unsigned HC_ACK        = 7;
  // Trigger source select codes
  localparam logic [1:0]  SRC_CHAN_A    = 2'h0;
  localparam logic [1:0]  SRC_CHAN_B    = 2'h1;
  localparam logic [1:0]  SRC_SOFT      = 2'h2;
  localparam logic [1:0]  SRC_EXT       = 2'h3;
  // Command codes
  localparam logic [1:0]  CMD_IDLE      = 2'h0;
  localparam logic [1:0]  CMD_RESET     = 2'h1;
  localparam logic [1:0]  CMD_LOAD      = 2'h2;
  localparam logic [1:0]  CMD_HALT_ARM  = 2'h3;
  localparam logic [7:0]  PORT_RST      = 8'h00;
  typedef enum logic [2:0] {
    TDS_ST_BOARD_RST, TDS_ST_ARMED, TDS_ST_RAMP1, TDS_ST_GATE,
    TDS_ST_COUNT, TDS_ST_RAMP2, TDS_ST_SAMPLE1, TDS_ST_SAMPLE2
  } tds_state_t;
endpackage : tds_pkg

// *** tds_host.sv ***
// Purpose: Host model that drives the sequencer's Wishbone port map
// Assumes: Classic single cycles, one request at a time
// Notes:   Word writes reach both chips; low byte is the low chip
`timescale 1ns/1ns
module tds_host
  import tds_pkg::*;
(
  input  wire logic        clk_i,  // Bench clock
  input  wire logic        ack_i,  // Slave acknowledge
  input  wire logic [15:0] dat_i,  // Slave read data
  output logic             cyc_o,  // Cycle
  output logic             stb_o,  // Strobe
  output logic             we_o,   // Write enable
  output logic [3:1]       adr_o,  // Word address
  output logic [1:0]       sel_o,  // Byte lanes
  output logic [15:0]      dat_o   // Write data
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 3'h0;
    sel_o = 2'h0;
    dat_o = 16'h0000;
  end

  // Held until ack; the bench timeout covers a slave that never answers
  task automatic xfer(input logic w, input logic [2:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 2'h3;
    dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
  endtask : xfer

  // Long integer: fine in bits 7:0, coarse count above it
  task automatic set_delay(input logic [31:0] v);
    logic [15:0] q;
    xfer(1'b1, {1'b0, PORT_A}, {v[23:16], v[7:0]}, q);
    xfer(1'b1, {1'b0, PORT_B}, {v[31:24], v[15:8]}, q);
  endtask : set_delay

  task automatic set_ctrl(input logic [1:0] src, input logic [1:0] c,
                          input logic a, input logic [9:0] lvl);
    logic [15:0] q;
    xfer(1'b1, {1'b0, PORT_C}, {a, 1'b0, c, src, lvl}, q);
  endtask : set_ctrl
endmodule : tds_host

// *** tds_top_tb_top.sv ***
// Purpose: Self-checking bench for the delay sequencer
// Assumes: Host model issues every bus cycle; bench plays the analog side
// Notes:   Coarse count kept small so each shot ends in tens of cycles
`timescale 1ns/1ns
module tds_top_tb_top;
  import tds_pkg::*;
  localparam logic [9:0] LVL   = 10'h2a5;
  localparam int         LIMIT = 20000;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i, stb_i, we_i, cmp_i = 1'b0;
  logic [3:1] adr_i;
  logic [1:0] sel_i;
  logic [15:0] dat_i, dat_o, q;
  logic ack_o, ramp_on_o, ramp_preset_o, hold_sample_o, hold_active_o;
  logic cmp_latch_o, sample1_o, sample2_o, ready_o, irq_o, halt_o, hit;
  logic [2:0] trig_n = 3'h7;
  logic kbd_irq_i = 1'b0, gpib_irq_i = 1'b0;
  logic [7:0] fine_delay_o;
  logic [9:0] trig_level_o;
  logic [1:0] src;
  int mismatches = 0, tests_run = 0, cycles = 0;

  tds_top tds_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .trig_a_n_i(trig_n[0]), .trig_b_n_i(trig_n[1]),
    .trig_ext_n_i(trig_n[2]), .cmp_i(cmp_i), .kbd_irq_i(kbd_irq_i),
    .gpib_irq_i(gpib_irq_i), .fine_delay_o(fine_delay_o),
    .trig_level_o(trig_level_o), .ramp_on_o(ramp_on_o),
    .ramp_preset_o(ramp_preset_o), .hold_sample_o(hold_sample_o),
    .hold_active_o(hold_active_o), .cmp_latch_o(cmp_latch_o),
    .sample1_o(sample1_o), .sample2_o(sample2_o), .ready_o(ready_o),
    .irq_o(irq_o), .halt_o(halt_o));

  tds_host tds_host_i (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o),
    .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i),
    .sel_o(sel_i), .dat_o(dat_i));

  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("checks=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic pick(input int s);
    case (s)
      0: pick = ramp_on_o;
      1: pick = sample1_o;
      2: pick = irq_o;
      default: pick = ready_o;
    endcase
  endfunction : pick

  // Values seen here are those sampled at the rising edge
  task automatic wait_sig(input int s, input logic v, input int lim);
    int n;
    n = 0;
    hit = 1'b0;
    while (n < lim && !hit) begin
      @(posedge clk_i);
      hit = (pick(s) === v);
      n++;
    end
  endtask : wait_sig

  task automatic ctl(input logic [1:0] c, input logic a);
    tds_host_i.set_ctrl(src, c, a, LVL);
  endtask : ctl

  task automatic arm(input logic h);
    ctl(CMD_LOAD, 1'b0);
    ctl(CMD_IDLE, 1'b0);
    chk(fine_delay_o, 8'ha5);
    chk(trig_level_o, LVL);
    chk(ready_o, 1'b1);
    if (h) begin
      ctl(CMD_HALT_ARM, 1'b0);
    end
    ctl(CMD_RESET, 1'b0);
    ctl(CMD_IDLE, 1'b0);
    wait_sig(3, 1'b0, 20);
    chk(hit, 1'b1);
    chk(ramp_preset_o, 1'b0);
    chk(cmp_latch_o, 1'b0);
    // Halt rises one edge after the reset line returns high
    @(posedge clk_i);
    chk(halt_o, h);
  endtask : arm

  // From the gated count to sample done and host acknowledge
  task automatic finish();
    wait_sig(0, 1'b0, 20);
    chk(hit, 1'b1);
    wait_sig(0, 1'b1, 200);
    chk(hit, 1'b1);
    cmp_i <= 1'b1;
    wait_sig(1, 1'b1, 20);
    chk(hit, 1'b1);
    @(posedge clk_i);
    chk(sample2_o, 1'b1);
    cmp_i <= 1'b0;
    wait_sig(2, 1'b1, 10);
    chk(hit, 1'b1);
    wait_sig(3, 1'b1, 10);
    chk(hit, 1'b1);
    chk(ramp_on_o, 1'b0);
    chk(ramp_preset_o, 1'b1);
    chk(cmp_latch_o, 1'b1);
    chk(halt_o, 1'b0);
    tds_host_i.xfer(1'b0, STATUS_ADR, 16'h0000, q);
    chk(q & 16'h00d4, 16'h0054);
    ctl(CMD_IDLE, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    chk(hold_active_o, 1'b0);
    ctl(CMD_IDLE, 1'b0);
  endtask : finish

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(fine_delay_o, 8'hff);
    chk(trig_level_o, 10'h000);
    chk(ready_o, 1'b1);
    chk(ramp_preset_o, 1'b1);
    chk({halt_o, irq_o, ramp_on_o}, 3'h0);
    tds_host_i.xfer(1'b0, STATUS_ADR, 16'h0000, q);
    chk(q & 16'h00f8, 16'h0030);
    tds_host_i.xfer(1'b1, 3'h5, 16'hffff, q);
    tds_host_i.xfer(1'b0, 3'h5, 16'h0000, q);
    chk(q, 16'h0000);
    // Coarse 0xfffff0 inverts to 15, counted out in 16 ticks; fine 0x5a inverts to 0xa5
    tds_host_i.set_delay(32'hfffff05a);
    src = SRC_SOFT;
    arm(1'b1);
    wait_sig(0, 1'b1, 20);
    chk(hit, 1'b1);
    finish();
    for (int i = 0; i < 3; i++) begin
      src = (i == 2) ? SRC_EXT : i[1:0];
      arm(1'b1);
      trig_n <= 3'h1 << i;
      wait_sig(0, 1'b1, 60);
      chk(hit, 1'b0);
      trig_n <= 3'h7;
      kbd_irq_i <= (i != 1);
      gpib_irq_i <= (i == 1);
      @(posedge clk_i);
      kbd_irq_i <= 1'b0;
      gpib_irq_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(halt_o, 1'b0);
      repeat (25) @(posedge clk_i);
      trig_n <= ~(3'h1 << i);
      wait_sig(0, 1'b1, 40);
      chk(hit, 1'b1);
      chk(hold_sample_o, 1'b1);
      trig_n <= 3'h7;
      finish();
    end
    results();
  end
endmodule : tds_top_tb_top
